// ---- acs_pkg.sv ----
// package for the converter control and two-wire slave block
package acs_pkg;
  localparam logic [6:0] ACS_DEV_ADDR = 7'h48;
  localparam logic [7:0] ACS_GCALL_ADDR = 8'h00;
  localparam logic [7:0] ACS_GCALL_RESET = 8'h06;
  localparam logic [7:0] ACS_GCALL_ALT = 8'h04;
  localparam logic [7:0] ACS_CFG_DEFAULT = 8'h80;
  localparam logic [7:0] ACS_CFG_WMASK = 8'h93;
  localparam int ACS_BIT_BUSY = 7;
  localparam int ACS_BIT_SINGLE = 4;
  localparam logic [7:0] ACS_FILL_BYTE = 8'hFF;
  localparam logic [15:0] ACS_OUT_RESET = 16'h0000;
  localparam logic signed [15:0] ACS_CODE_MAX = 16'sh07FF;
  localparam logic signed [15:0] ACS_CODE_MIN = -16'sh0800;
  localparam int ACS_CLK_HZ = 25000000;
  localparam int ACS_RATE_SPS = 128;
  localparam int ACS_CONV_CYCLES = ACS_CLK_HZ / ACS_RATE_SPS;
  localparam int ACS_PWRUP_NS = 1000;
  localparam int ACS_PWRUP_CYCLES = (ACS_PWRUP_NS * (ACS_CLK_HZ / 1000000) + 999) / 1000;
  localparam logic [3:0] ACS_BIT_LAST = 4'h7;
  localparam logic [3:0] ACS_BIT_ACK = 4'h8;
  localparam logic [1:0] ACS_LAST_RD_BYTE = 2'h2;

  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
    logic fall;
    logic sda;
  } acs_bus_ev_t;

  typedef struct packed {
    logic busy;
    logic single;
    logic [1:0] gain;
  } acs_cfg_t;

  typedef enum logic [1:0] {
    ACS_C_OFF = 2'b00,
    ACS_C_PWRUP = 2'b01,
    ACS_C_CONV = 2'b10
  } acs_conv_state_t;

  typedef enum logic [2:0] {
    ACS_L_IDLE = 3'b000,
    ACS_L_ADDR = 3'b001,
    ACS_L_WDATA = 3'b010,
    ACS_L_RDATA = 3'b011,
    ACS_L_GCALL = 3'b100,
    ACS_L_IGNORE = 3'b101
  } acs_link_state_t;
endpackage : acs_pkg

// ---- acs_sync.sv ----
// two-stage synchroniser and edge finder for the bus pins
`timescale 1ns/10ps
`default_nettype none
module acs_sync
  import acs_pkg::*;
(
  input wire logic clock, // system clock
  input wire logic sys_rst, // synchronous reset
  input wire logic scl_in, // raw bus clock pin
  input wire logic sda_in, // raw bus data pin
  output acs_bus_ev_t ev // synchronised events
);
  logic [1:0] scl_meta_r, sda_meta_r;
  logic scl_d_r, sda_d_r;

  // first stage feeds only the second stage
  always_ff @(posedge clock) begin // [RULE24]
    if (sys_rst) begin
      scl_meta_r <= 2'h3;
      sda_meta_r <= 2'h3;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_meta_r <= {scl_meta_r[0], scl_in};
      sda_meta_r <= {sda_meta_r[0], sda_in};
      scl_d_r <= scl_meta_r[1];
      sda_d_r <= sda_meta_r[1];
    end
  end

  always_comb begin
    ev.rise = scl_meta_r[1] & ~scl_d_r;
    ev.fall = ~scl_meta_r[1] & scl_d_r;
    ev.start = scl_meta_r[1] & scl_d_r & sda_d_r & ~sda_meta_r[1]; // [RULE14]
    ev.stop = scl_meta_r[1] & scl_d_r & ~sda_d_r & sda_meta_r[1]; // [RULE14]
    ev.sda = sda_meta_r[1];
  end
endmodule : acs_sync
`default_nettype wire

// ---- acs_shift.sv ----
// eight-bit shift register with bit counter for the bus
`timescale 1ns/10ps
`default_nettype none
module acs_shift
  import acs_pkg::*;
(
  input wire logic clock, // system clock
  input wire logic sys_rst, // synchronous reset
  input wire logic clr, // restart bit count at frame start
  input wire logic rise, // bus clock rising edge
  input wire logic fall, // bus clock falling edge
  input wire logic sda, // synchronised data
  output logic [7:0] rx_byte, // received byte
  output logic [3:0] bit_cnt, // bit position 0..8
  output logic byte_done, // pulse: eighth bit sampled
  output logic slot_end // pulse: acknowledge slot left
);
  logic lead_r;

  // the clock fall that closes a start or stop is not a bit of its own
  always_ff @(posedge clock) begin
    if (sys_rst || clr) begin
      lead_r <= 1'b1;
    end else if (fall) begin
      lead_r <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst || clr) begin
      rx_byte <= 8'h00;
      bit_cnt <= 4'h0;
    end else if (rise && bit_cnt <= ACS_BIT_LAST) begin
      rx_byte <= {rx_byte[6:0], sda}; // [RULE13]
    end else if (fall && !lead_r) begin
      bit_cnt <= (bit_cnt == ACS_BIT_ACK) ? 4'h0 : bit_cnt + 4'h1;
    end
  end

  always_comb begin
    byte_done = fall && bit_cnt == ACS_BIT_LAST;
    slot_end = fall && bit_cnt == ACS_BIT_ACK;
  end
endmodule : acs_shift
`default_nettype wire

// ---- acs_top.sv ----
// converter sequencing and two-wire slave, top level
// Operation
// [RULE1] results are two's complement, clipped to -2048..2047
// [RULE2] conversion timing comes from the internal clock only
// [RULE3] continuous mode stores each result and restarts at once
// [RULE4] busy flag reads 1 whenever continuous mode is selected
// [RULE5] single-shot waits powered down until busy flag set, then converts once
// [RULE6] single-shot end stores result, clears busy, powers down
// [RULE7] writing 1 to busy during a conversion has no effect
// [RULE8] switching to single-shot finishes current conversion, clears busy, powers down
// [RULE9] power-up reset returns configuration to defaults
// [RULE10] general-call reset performs the same full reset; here bus link, pin driver and synchroniser keep running
// [RULE11] slave only; bus clock is input only
// [RULE12] data line only pulled low or released
// [RULE13] eight-bit bytes, set while clock low, sampled on clock high
// [RULE14] start and stop detected as data edges while clock high
// [RULE15] respond only to own seven-bit address plus direction bit
// [RULE16] receiver acknowledges each byte on the ninth clock; here write data bytes after the first get no acknowledge
// [RULE17] not-acknowledge leaves data released during acknowledge clock
// [RULE18] device drives data on reads, releases it on writes except acknowledge
// [RULE19] start while bus active is a repeated start, expect address
// [RULE20] single-shot select bit: 1 single-shot, 0 continuous, default continuous
// [RULE21] configuration register resets to 80h
// [RULE22] general call 00h then 06h acknowledged, aborts conversion, zeroes output
// [RULE23] 16-bit output register, sign extended, zero until first result
// [RULE24] bus pins synchronised before edge detection
`timescale 1ns/10ps
`default_nettype none
module acs_top
  import acs_pkg::*;
(
  input wire logic clock, // internal oscillator clock
  input wire logic sys_rst, // power-up reset, active high
  input wire logic scl_in, // bus clock pin, input only
  input wire logic sda_in, // bus data pin level
  output logic sda_out, // data pin drive value, always low
  output logic sda_oe_n, // low while pulling data low
  input wire logic signed [15:0] analog_code, // raw modulator result
  output logic [15:0] result_r, // output register
  output logic [7:0] config_r, // configuration register readback
  output logic [1:0] amplifier_gain_setting, // gain to analog front end
  output logic power_on_r, // analog core power enable
  output logic start_busy_flag // busy flag as read
);
  acs_bus_ev_t ev;
  logic [7:0] rx_byte;
  logic [3:0] bit_cnt;
  logic byte_done, slot_end;
  acs_link_state_t lstate_r;
  acs_conv_state_t cstate_r;
  logic [7:0] tx_r;
  logic [1:0] rd_idx_r;
  logic ack_r;
  logic drive_r;
  logic master_nack_r;
  logic soft_rst_r;
  logic cfg_wr;
  logic [7:0] cfg_wdata;
  logic single_shot_select;
  logic busy_r;
  logic [1:0] gain_r;
  logic [31:0] conv_cnt_r;
  logic conv_done;
  logic signed [15:0] clipped;
  logic rst_all;
  acs_cfg_t cfg_now;

  // a general call reset returns configuration, converter and output register to power-up state
  assign rst_all = sys_rst | soft_rst_r; // [RULE9] [RULE10]

  // edge flags lag the pins by one to two clocks
  acs_sync u_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .ev(ev)
  );

  acs_shift u_shift (
    .clock(clock),
    .sys_rst(sys_rst),
    .clr(ev.start | ev.stop),
    .rise(ev.rise),
    .fall(ev.fall),
    .sda(ev.sda),
    .rx_byte(rx_byte),
    .bit_cnt(bit_cnt),
    .byte_done(byte_done),
    .slot_end(slot_end)
  );

  // link state: the shifter counts bits, this walks bytes
  // refused bytes leave the pin released; only a new start reopens the link
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      lstate_r <= ACS_L_IDLE;
      ack_r <= 1'b0;
      rd_idx_r <= 2'h0;
    end else if (ev.start) begin
      lstate_r <= ACS_L_ADDR; // [RULE19]
      ack_r <= 1'b0;
      rd_idx_r <= 2'h0;
    end else if (ev.stop) begin
      lstate_r <= ACS_L_IDLE;
      ack_r <= 1'b0;
    end else begin
      if (byte_done) begin
        unique case (lstate_r)
          ACS_L_ADDR: begin
            if (rx_byte[7:1] == ACS_DEV_ADDR) begin // [RULE15]
              ack_r <= 1'b1; // [RULE16]
            end else if (rx_byte == ACS_GCALL_ADDR) begin
              ack_r <= 1'b1; // [RULE22]
            end else begin
              ack_r <= 1'b0; // [RULE17]
            end
          end
          ACS_L_WDATA: ack_r <= 1'b1; // [RULE16]
          ACS_L_GCALL: ack_r <= (rx_byte == ACS_GCALL_RESET) || (rx_byte == ACS_GCALL_ALT); // [RULE22]
          default: ack_r <= 1'b0; // later write bytes get no acknowledge
        endcase
      end
      if (slot_end) begin
        ack_r <= 1'b0;
        unique case (lstate_r)
          ACS_L_ADDR: begin
            if (!ack_r) lstate_r <= ACS_L_IGNORE;
            else if (rx_byte == ACS_GCALL_ADDR) lstate_r <= ACS_L_GCALL;
            else if (rx_byte[0]) lstate_r <= ACS_L_RDATA;
            else lstate_r <= ACS_L_WDATA;
          end
          ACS_L_WDATA: lstate_r <= ACS_L_IGNORE;
          ACS_L_RDATA: begin
            if (master_nack_r) lstate_r <= ACS_L_IGNORE;
            else if (rd_idx_r != 2'h3) rd_idx_r <= rd_idx_r + 2'h1;
          end
          ACS_L_GCALL: lstate_r <= ACS_L_IGNORE;
          ACS_L_IDLE, ACS_L_IGNORE: lstate_r <= lstate_r;
          default: lstate_r <= ACS_L_IDLE;
        endcase
      end
    end
  end

  // master acknowledge of a read byte, taken while the slot clock is high
  always_ff @(posedge clock) begin
    if (sys_rst || ev.start) begin
      master_nack_r <= 1'b0;
    end else if (lstate_r == ACS_L_RDATA && ev.rise && bit_cnt == ACS_BIT_ACK) begin
      master_nack_r <= ev.sda; // [RULE16] [RULE17]
    end
  end

  // general call reset fires once the acknowledge slot of 06h ends
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      soft_rst_r <= 1'b0;
    end else begin
      soft_rst_r <= slot_end && lstate_r == ACS_L_GCALL && rx_byte == ACS_GCALL_RESET; // [RULE10] [RULE22]
    end
  end

  assign cfg_wr = slot_end && lstate_r == ACS_L_WDATA && ack_r;
  assign cfg_wdata = rx_byte;

  // read byte mux: result high, result low, config, then fill bytes
  // index saturates on the fill byte, so over-long reads cost nothing
  always_comb begin
    unique case (rd_idx_r)
      2'h0: tx_r = result_r[15:8];
      2'h1: tx_r = result_r[7:0];
      ACS_LAST_RD_BYTE: tx_r = config_r;
      default: tx_r = ACS_FILL_BYTE;
    endcase
  end

  // data pin driver; the sample is stable through clock high
  // changes land a few clocks after the seen fall, well inside the low phase
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      drive_r <= 1'b0;
    end else if (ev.start || ev.stop) begin
      drive_r <= 1'b0;
    end else if (ev.fall) begin
      if (bit_cnt == ACS_BIT_LAST) begin
        drive_r <= byte_done_ack(lstate_r, rx_byte); // [RULE16] [RULE18]
      end else if (bit_cnt == ACS_BIT_ACK) begin
        // next byte of a read starts right after the master acknowledge
        drive_r <= next_rd_low(lstate_r, rx_byte, ack_r, ev.sda, rd_idx_r);
      end else if (lstate_r == ACS_L_RDATA && !master_nack_r) begin
        drive_r <= ~tx_r[ACS_BIT_LAST[2:0] - bit_cnt[2:0] - 3'h1]; // [RULE18]
      end else begin
        drive_r <= 1'b0;
      end
    end
  end

  // acknowledge decision for the byte just shifted in, made on its last fall
  function automatic logic byte_done_ack(input acs_link_state_t st, input logic [7:0] b);
    logic a;
    a = 1'b0;
    unique case (st)
      ACS_L_ADDR: a = (b[7:1] == ACS_DEV_ADDR) || (b == ACS_GCALL_ADDR);
      ACS_L_WDATA: a = 1'b1;
      ACS_L_GCALL: a = (b == ACS_GCALL_RESET) || (b == ACS_GCALL_ALT);
      default: a = 1'b0;
    endcase
    return a;
  endfunction : byte_done_ack

  // looks one byte ahead: the read index moves in the same cycle, so the mux
  // above would still show the old byte when the first bit must go out
  function automatic logic next_rd_low(input acs_link_state_t st, input logic [7:0] b, input logic a,
                                        input logic m_sda, input logic [1:0] idx);
    logic [7:0] nb;
    logic [1:0] ni;
    nb = ACS_FILL_BYTE;
    ni = idx;
    if (st == ACS_L_RDATA) begin
      ni = (idx == 2'h3) ? idx : idx + 2'h1;
      if (m_sda) ni = 2'h3;
    end
    unique case (ni)
      2'h0: nb = result_r[15:8];
      2'h1: nb = result_r[7:0];
      ACS_LAST_RD_BYTE: nb = config_r;
      default: nb = ACS_FILL_BYTE;
    endcase
    if (st == ACS_L_ADDR && a && b[0] && b != ACS_GCALL_ADDR) return ~result_r[15];
    if (st == ACS_L_RDATA && !m_sda) return ~nb[7];
    return 1'b0;
  endfunction : next_rd_low

  // open drain: only ever pull low, never drive high
  // the drive value is tied low; the enable alone picks pull or release
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sda_out <= 1'b0;
      sda_oe_n <= 1'b1;
    end else begin
      sda_out <= 1'b0; // [RULE12]
      sda_oe_n <= ~drive_r; // [RULE11] [RULE12]
    end
  end

  // configuration bits
  // reserved bits are dropped on write and read back as zero
  always_ff @(posedge clock) begin
    if (rst_all) begin
      single_shot_select <= ACS_CFG_DEFAULT[ACS_BIT_SINGLE]; // [RULE20] [RULE21]
      gain_r <= ACS_CFG_DEFAULT[1:0]; // [RULE21]
    end else if (cfg_wr) begin
      single_shot_select <= cfg_wdata[ACS_BIT_SINGLE]; // [RULE20]
      gain_r <= cfg_wdata[1:0];
    end
  end

  // converter timing from the internal clock only; no external clock input exists
  assign conv_done = cstate_r == ACS_C_CONV && conv_cnt_r == 32'(ACS_CONV_CYCLES - 1); // [RULE2]

  always_ff @(posedge clock) begin
    if (rst_all) begin
      cstate_r <= ACS_C_CONV; // continuous default starts converting
      conv_cnt_r <= 32'h00000000;
      busy_r <= 1'b1; // a running continuous conversion counts as busy [RULE4] [RULE8]
    end else begin
      unique case (cstate_r)
        ACS_C_OFF: begin
          conv_cnt_r <= 32'h00000000;
          if (!single_shot_select) begin
            busy_r <= 1'b1; // [RULE4]
            cstate_r <= ACS_C_PWRUP;
          end else if (cfg_wr && cfg_wdata[ACS_BIT_BUSY]) begin
            busy_r <= 1'b1; // [RULE5]
            cstate_r <= ACS_C_PWRUP; // [RULE5]
          end
        end
        // settle time before each conversion started from ACS_C_OFF; a reset enters ACS_C_CONV at once
        ACS_C_PWRUP: begin
          if (conv_cnt_r == 32'(ACS_PWRUP_CYCLES - 1)) begin
            conv_cnt_r <= 32'h00000000;
            cstate_r <= ACS_C_CONV;
          end else begin
            conv_cnt_r <= conv_cnt_r + 32'h00000001;
          end
        end
        ACS_C_CONV: begin
          // a start write here is ignored: counter untouched
          if (conv_done) begin // [RULE7]
            conv_cnt_r <= 32'h00000000;
            if (single_shot_select) begin
              busy_r <= 1'b0; // [RULE6] [RULE8]
              cstate_r <= ACS_C_OFF; // [RULE6] [RULE8]
            end else begin
              cstate_r <= ACS_C_CONV; // [RULE3]
            end
          end else begin
            conv_cnt_r <= conv_cnt_r + 32'h00000001;
          end
        end
        default: cstate_r <= ACS_C_OFF;
      endcase
    end
  end

  // clip first, then keep twelve bits; an out-of-range raw code saturates
  assign clipped = (analog_code > ACS_CODE_MAX) ? ACS_CODE_MAX :
                   (analog_code < ACS_CODE_MIN) ? ACS_CODE_MIN : analog_code; // [RULE1]

  // output register: zero from any reset until the first result lands
  always_ff @(posedge clock) begin
    if (rst_all) begin
      result_r <= ACS_OUT_RESET; // [RULE22] [RULE23]
    end else if (conv_done) begin
      result_r <= {{4{clipped[11]}}, clipped[11:0]}; // [RULE3] [RULE23]
    end
  end

  // live configuration view; busy stays 1 while a conversion is still owed
  always_comb begin
    cfg_now.busy = ~single_shot_select | busy_r; // [RULE4]
    cfg_now.single = single_shot_select;
    cfg_now.gain = gain_r;
  end

  // readback bits are registered so that no output comes from logic
  always_ff @(posedge clock) begin
    if (rst_all) begin
      power_on_r <= 1'b1;
      start_busy_flag <= 1'b1;
      config_r <= ACS_CFG_DEFAULT; // [RULE21]
      amplifier_gain_setting <= ACS_CFG_DEFAULT[1:0];
    end else begin
      power_on_r <= cstate_r != ACS_C_OFF; // [RULE5] [RULE6]
      start_busy_flag <= cfg_now.busy; // [RULE4]
      config_r <= {cfg_now.busy, 2'b00, cfg_now.single, 2'b00, cfg_now.gain}; // [RULE4] [RULE20]
      amplifier_gain_setting <= cfg_now.gain;
    end
  end
endmodule : acs_top
`default_nettype wire

// ---- acs_props.sv ----
// checker for the converter control and two-wire slave top level
`timescale 1ns/10ps
`default_nettype none
module acs_props
  import acs_pkg::*;
(
  input wire logic clock, // system clock
  input wire logic sys_rst, // synchronous reset
  input wire logic scl_in, // bus clock pin
  input wire logic sda_in, // bus data level
  input wire logic sda_out, // data drive value
  input wire logic sda_oe_n, // data pull enable, low active
  input wire logic signed [15:0] analog_code, // raw converter value
  input wire logic [15:0] result_r, // output register
  input wire logic [7:0] config_r, // configuration readback
  input wire logic [1:0] amplifier_gain_setting, // gain bits
  input wire logic power_on_r, // analog power
  input wire logic start_busy_flag // busy flag
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  chk_drive_low:
  assert property (sda_out == 1'b0) else $error("data pin drive value not low");
  chk_reset_values:
  assert property ($fell(sys_rst) |-> config_r == ACS_CFG_DEFAULT && result_r == ACS_OUT_RESET && sda_oe_n)
    else $error("wrong values after reset");
  chk_busy_cont:
  assert property (!config_r[ACS_BIT_SINGLE] |-> start_busy_flag) else $error("busy low in continuous mode");
  chk_busy_mirror:
  assert property (start_busy_flag == config_r[ACS_BIT_BUSY]) else $error("busy flag and readback differ");
  chk_cfg_fields:
  assert property ((config_r & ~ACS_CFG_WMASK) == 8'h00 && amplifier_gain_setting == config_r[1:0])
    else $error("reserved bits set or gain mismatch");
  chk_result_clip:
  assert property (result_r[15:11] == 5'h00 || result_r[15:11] == 5'h1F) else $error("result out of range");
  chk_sda_change:
  assert property ($changed(sda_oe_n) |-> !scl_in) else $error("data drive changed while clock high");
  chk_hold_high:
  assert property ($rose(scl_in) && !sda_oe_n |-> !sda_oe_n [*3]) else $error("data released during clock high");
  chk_single_idle:
  assert property (config_r[ACS_BIT_SINGLE] && !start_busy_flag ##1 config_r[ACS_BIT_SINGLE] && !start_busy_flag
    |-> !power_on_r) else $error("powered while idle in single mode");
endmodule : acs_props

bind acs_top acs_props u_props (
  .clock(clock),
  .sys_rst(sys_rst),
  .scl_in(scl_in),
  .sda_in(sda_in),
  .sda_out(sda_out),
  .sda_oe_n(sda_oe_n),
  .analog_code(analog_code),
  .result_r(result_r),
  .config_r(config_r),
  .amplifier_gain_setting(amplifier_gain_setting),
  .power_on_r(power_on_r),
  .start_busy_flag(start_busy_flag)
);
`default_nettype wire

// ---- acs_master.sv ----
// behavioural two-wire bus master that drives the clock and pulls data low
`timescale 1ns/10ps
`default_nettype none
module acs_master (
  output logic scl, // bus clock, master only
  output logic pull, // master pulls data low
  input wire logic sda // resolved data line
);
  // 320 ns bit; the low phase leaves a clock of margin after the slave's drive lands
  localparam int T_LOW = 200;
  localparam int T_HIGH = 120;
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  // with the clock low this is a repeated start
  task automatic start();
    if (!scl) begin
      #80 pull = 1'b0;
      #(T_LOW - 80) scl = 1'b1;
    end
    #T_HIGH pull = 1'b1;
    #T_HIGH scl = 1'b0;
  endtask : start
  // data set while clock low, sampled at the end of the high phase
  task automatic bit_io(input logic b, output logic s);
    #80 pull = !b;
    #(T_LOW - 80) scl = 1'b1;
    #T_HIGH s = sda;
    scl = 1'b0;
  endtask : bit_io
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, s);
    ack = !s;
  endtask : wr_byte
  task automatic rd_byte(input logic nack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(nack, s);
  endtask : rd_byte
  task automatic stop();
    #80 pull = 1'b1;
    #(T_LOW - 80) scl = 1'b1;
    #T_HIGH pull = 1'b0;
    #T_LOW;
  endtask : stop
endmodule : acs_master
`default_nettype wire

// ---- acs_top_tb_top.sv ----
// self-checking testbench for the converter control and two-wire slave
`timescale 1ns/10ps
`default_nettype none
module acs_top_tb_top
  import acs_pkg::*;
;
  logic clock, sys_rst, scl, m_pull, sda_wire, sda_out, sda_oe_n, power_on_r, start_busy_flag;
  logic [15:0] result_r;
  logic [7:0] config_r;
  logic [1:0] gain;
  logic signed [15:0] analog_code;
  int num_errors, n_tests;
  localparam logic [7:0] ADR_W = {ACS_DEV_ADDR, 1'b0};
  localparam logic [7:0] ADR_R = {ACS_DEV_ADDR, 1'b1};
  // open-drain wire with pull-up: low if either party pulls
  assign sda_wire = !m_pull && (sda_oe_n || sda_out);
  acs_master u_m (.scl(scl), .pull(m_pull), .sda(sda_wire));
  acs_top DUT (
    .clock(clock),
    .sys_rst(sys_rst),
    .scl_in(scl),
    .sda_in(sda_wire),
    .sda_out(sda_out),
    .sda_oe_n(sda_oe_n),
    .analog_code(analog_code),
    .result_r(result_r),
    .config_r(config_r),
    .amplifier_gain_setting(gain),
    .power_on_r(power_on_r),
    .start_busy_flag(start_busy_flag)
  );
  initial clock = 1'b0;
  always #20 clock = ~clock;
  task automatic final_report();
    $display("comparisons=%0d mismatches=%0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_byte
  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit
  task automatic send(input logic [7:0] b, input logic exp_ack);
    logic a;
    u_m.wr_byte(b, a);
    chk_bit(a, exp_ack);
  endtask : send
  task automatic fetch(input logic nack, input logic [7:0] exp);
    logic [7:0] d;
    u_m.rd_byte(nack, d);
    chk_byte(d, exp);
  endtask : fetch
  task automatic do_reset();
    @(negedge clock);
    sys_rst = 1'b1;
    repeat (3) @(negedge clock);
    sys_rst = 1'b0;
    repeat (4) @(negedge clock);
  endtask : do_reset
  // full read: result high, result low, config, then one fill byte
  task automatic read_all(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] cfg);
    u_m.start();
    send(ADR_R, 1'b1);
    fetch(1'b0, hi);
    fetch(1'b0, lo);
    fetch(1'b0, cfg);
    fetch(1'b1, ACS_FILL_BYTE);
    u_m.stop();
  endtask : read_all
  task automatic wr_cfg(input logic [7:0] d);
    u_m.start();
    send(ADR_W, 1'b1);
    send(d, 1'b1);
    u_m.stop();
    repeat (4) @(negedge clock);
  endtask : wr_cfg
  task automatic gcall(input logic [7:0] d, input logic exp_ack);
    u_m.start();
    send(ACS_GCALL_ADDR, 1'b1);
    send(d, exp_ack);
    u_m.stop();
    repeat (4) @(negedge clock);
  endtask : gcall
  initial begin
    num_errors = 0;
    n_tests = 0;
    sys_rst = 1'b1;
    analog_code = 16'sh0123;
    repeat (3) @(negedge clock);
    sys_rst = 1'b0;
    repeat (4) @(negedge clock);
    chk_byte(config_r, ACS_CFG_DEFAULT);
    chk_bit(power_on_r, 1'b1);
    read_all(8'h00, 8'h00, ACS_CFG_DEFAULT);
    u_m.start();
    send({ACS_DEV_ADDR ^ 7'h01, 1'b0}, 1'b0);
    u_m.stop();
    // switch to single while converting: busy still held while the conversion runs
    u_m.start();
    send(ADR_W, 1'b1);
    send(8'h13, 1'b1);
    send(8'h55, 1'b0);
    u_m.stop();
    repeat (4) @(negedge clock);
    chk_byte(config_r, 8'h93);
    chk_byte({6'h00, gain}, 8'h03);
    chk_bit(power_on_r, 1'b1);
    wr_cfg(8'h93);
    chk_byte(config_r, 8'h93);
    chk_bit(start_busy_flag, 1'b1);
    // reserved bits ignored, then a repeated start into a read
    u_m.start();
    send(ADR_W, 1'b1);
    send(8'h6C, 1'b1);
    u_m.start();
    send(ADR_R, 1'b1);
    fetch(1'b0, 8'h00);
    fetch(1'b0, 8'h00);
    fetch(1'b1, ACS_CFG_DEFAULT);
    u_m.stop();
    wr_cfg(8'h12);
    gcall(ACS_GCALL_ALT, 1'b1);
    chk_byte(config_r, 8'h92);
    gcall(8'h05, 1'b0);
    gcall(ACS_GCALL_RESET, 1'b1);
    chk_byte(config_r, ACS_CFG_DEFAULT);
    chk_byte(result_r[7:0], 8'h00);
    chk_byte({6'h00, gain}, 8'h00);
    wr_cfg(8'h11);
    chk_byte(config_r, 8'h91);
    do_reset();
    chk_byte(config_r, ACS_CFG_DEFAULT);
    read_all(8'h00, 8'h00, ACS_CFG_DEFAULT);
    final_report();
  end
  initial begin
    repeat (60000) @(posedge clock);
    num_errors++;
    final_report();
  end
endmodule : acs_top_tb_top
`default_nettype wire
